// File: chop_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "chop_regs.svh"

module chop_channel
	import chop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic osc_edge,
	input wire logic limit,
	input wire logic dir,
	input wire logic hold,
	output bridge_t bridge,
	output chop_mode_t mode
);

	chan_state_t st_ff;
	chan_state_t nxt_st;
	bridge_t want;

	function automatic bridge_t drive(chop_mode_t m, logic d);
		case (m)
			MODE_CHARGE: drive = d ? `BR_CROSS_B : `BR_CROSS_A;
			MODE_SLOW: drive = `BR_SLOW;
			MODE_FAST: drive = d ? `BR_CROSS_A : `BR_CROSS_B;
			default: drive = `BR_OFF;
		endcase
	endfunction

	always_comb begin
		nxt_st = st_ff;
		want = `BR_OFF;
		if (hold) begin
			nxt_st.mode = MODE_OFF;
			nxt_st.count = 4'h0;
			nxt_st.dead = 3'h0;
			nxt_st.bridge = `BR_OFF;
		end else begin
			if (st_ff.mode == MODE_OFF) begin
				nxt_st.mode = MODE_CHARGE;
				nxt_st.count = 4'h0;
			end else if (osc_edge) begin
				if (st_ff.count == `CHOP_LAST) begin
					// one period per 16 edges; decay share fixed by the two compare points
					nxt_st.count = 4'h0;
					nxt_st.mode = MODE_CHARGE;
				end else begin
					nxt_st.count = 4'(st_ff.count + 4'h1);
					if (st_ff.count == `CHOP_FAST_AT)
						nxt_st.mode = MODE_FAST;
					else if (st_ff.mode == MODE_CHARGE && limit)
						nxt_st.mode = MODE_SLOW;
				end
			end else if (st_ff.mode == MODE_CHARGE && limit) begin
				nxt_st.mode = MODE_SLOW;
			end
			want = drive(nxt_st.mode, dir);
			// every change passes through all-off, costs a few cycles of drive
			if (want != st_ff.bridge) begin
				if (st_ff.bridge != `BR_OFF) begin
					nxt_st.bridge = `BR_OFF;
					nxt_st.dead = 3'(`DEAD_CYC);
				end else if (st_ff.dead != 3'h0) begin
					nxt_st.dead = 3'(st_ff.dead - 3'h1);
				end else begin
					nxt_st.bridge = want;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign bridge = st_ff.bridge;
	assign mode = st_ff.mode;

endmodule

`default_nettype wire

// File: chop_partner.sv
`timescale 1ns/1ps
`default_nettype none
module chop_partner
	import chop_pkg::*;
(
	input wire logic pclk,
	input wire logic limit_en,
	input wire logic [1:0] rev,
	input wire bridge_t bridge_a,
	input wire bridge_t bridge_b,
	output logic chop_osc_clock,
	output logic [1:0] current_limit_reached
);
	logic [5:0] a_ff;
	logic [5:0] b_ff;
	//////////
	// free-running rc oscillator, 8 pclk period, phase kept off the pclk edges
	initial begin
		chop_osc_clock = 1'b0;
		a_ff = 6'h00;
		b_ff = 6'h00;
		#5;
		forever #100 chop_osc_clock = ~chop_osc_clock;
	end
	//////////
	// current builds only on the charge diagonal; fast decay must not leave limit high
	always @(posedge pclk) begin
		a_ff <= (bridge_a == (rev[0] ? 4'h6 : 4'h9)) ? a_ff + 6'h01 : 6'h00;
		b_ff <= (bridge_b == (rev[1] ? 4'h6 : 4'h9)) ? b_ff + 6'h01 : 6'h00;
	end
	assign current_limit_reached = {limit_en && b_ff > 6'h13, limit_en && a_ff > 6'h13};
endmodule
`default_nettype wire

// File: chop_pkg.sv
package chop_pkg;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_CHARGE = 2'b01,
		MODE_SLOW = 2'b10,
		MODE_FAST = 2'b11
	} chop_mode_t;

	typedef struct packed {
		logic first_high_side_switch;
		logic second_high_side_switch;
		logic first_low_side_switch;
		logic second_low_side_switch;
	} bridge_t;

	typedef struct packed {
		chop_mode_t mode;
		logic [3:0] count;
		logic [2:0] dead;
		bridge_t bridge;
	} chan_state_t;

	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic osc_prev;
		logic [2:0] div;
		logic half;
		logic [3:0] oc_cnt;
		logic [3:0] ot_cnt;
		logic oc_latch;
		logic ot_latch;
		logic [2:0] ctrl;
		logic [1:0] int_stat;
		logic [1:0] int_mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} top_state_t;

endpackage

// File: chop_regs.svh
// Summary of operation
// - over-temperature trip sets its fault latch and forces every bridge switch off.
// - over-temperature trip must persist through a blanking interval before latching.
// - over-temperature latch clears only on supply re-assertion or standby.
// - over-current trip sets its fault latch and turns every bridge switch off.
// - over-current latch clears only on supply re-assertion or standby.
// - mixed decay share is fixed at 31.25 percent, not configurable.
// - each chopping period starts in charge when the oscillator count restarts at zero.
// - in charge, current limit reached moves the channel into slow decay.
// - slow decay turns into fast decay on the 11th oscillator rising edge.
// - at 16 oscillator edges fast decay ends, counter resets, charge restarts.
// - forward current switch table for charge, slow and fast decay.
// - reverse current switch table for charge, slow and fast decay.
// - modes sequence automatically with dead time at every switch change.
// - chopping frequency is oscillator frequency divided by 16.
// - over-current blanking lasts 7 to 8 cycles of the 6.4 MHz system tick (here sys_tick comes every 6 pclk cycles, about 6.67 MHz).
// - over-temperature blanking lasts 7 to 8 cycles of half the system tick.
`ifndef CHOP_REGS_SVH
`define CHOP_REGS_SVH

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_INT_STATUS 12'h008
`define REG_INT_MASK 12'h00C

`define CTRL_STANDBY 0
`define CTRL_DIR_A 1
`define CTRL_DIR_B 2
`define CTRL_RESET 3'h1

`define EV_OT 0
`define EV_OC 1

`define PIN_OSC 0
`define PIN_LIM_A 1
`define PIN_LIM_B 2
`define PIN_OC_A 3
`define PIN_OC_B 4
`define PIN_OT 5
`define PIN_SUPPLY 6

`define PCLK_KHZ 40000
`define SYS_CLK_KHZ 6400
`define SYS_DIV (`PCLK_KHZ / `SYS_CLK_KHZ)
`define OC_BLANK_TICKS 4'h8
`define OT_BLANK_TICKS 4'h8

`define CHOP_FAST_AT 4'hA
`define CHOP_LAST 4'hF

`define DEAD_NS 100
`define DEAD_CYC ((`DEAD_NS * `PCLK_KHZ + 999999) / 1000000)

`define BR_OFF 4'h0
`define BR_CROSS_A 4'h9
`define BR_CROSS_B 4'h6
`define BR_SLOW 4'h3

`endif

// File: chopper_decay_fault_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "chop_regs.svh"

module chopper_decay_fault_control
	import chop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chop_osc_clock,
	input wire logic [1:0] current_limit_reached,
	input wire logic [1:0] over_current_trip,
	input wire logic over_temp_trip,
	input wire logic motor_supply_good,
	output bridge_t bridge_a,
	output bridge_t bridge_b,
	output logic irq
);

	top_state_t st_ff;
	top_state_t nxt_st;
	chop_mode_t mode_a;
	chop_mode_t mode_b;
	logic osc_edge;
	logic sys_tick;
	logic half_tick;
	logic oc_det;
	logic ot_det;
	logic oc_ev;
	logic ot_ev;
	logic clr;
	logic hold;
	logic setup;
	logic access;
	logic [1:0] events;
	logic [31:0] rd;
	logic hit;

	////////////////////////////////////////////////////////////////////////
	// pin sampling and slow ticks

	always_comb begin
		osc_edge = st_ff.sync2[`PIN_OSC] & ~st_ff.osc_prev;
		sys_tick = (st_ff.div == 3'(`SYS_DIV - 1));
		half_tick = sys_tick & st_ff.half;
		oc_det = st_ff.sync2[`PIN_OC_A] | st_ff.sync2[`PIN_OC_B];
		ot_det = st_ff.sync2[`PIN_OT];
		// supply low counts as re-assertion pending; latch cleared there
		clr = st_ff.ctrl[`CTRL_STANDBY] | ~st_ff.sync2[`PIN_SUPPLY];
		oc_ev = oc_det & (st_ff.oc_cnt == `OC_BLANK_TICKS);
		ot_ev = ot_det & (st_ff.ot_cnt == `OT_BLANK_TICKS);
		hold = st_ff.oc_latch | st_ff.ot_latch | clr;
		setup = psel & ~penable;
		access = psel & penable & st_ff.pready;
		events = '0;
		events[`EV_OC] = oc_ev & ~st_ff.oc_latch & ~clr;
		events[`EV_OT] = ot_ev & ~st_ff.ot_latch & ~clr;
	end

	////////////////////////////////////////////////////////////////////////
	// register read decode

	always_comb begin
		rd = '0;
		hit = 1'b1;
		case (paddr)
			`REG_CTRL: rd[2:0] = st_ff.ctrl;
			`REG_STATUS: rd[5:0] = {mode_b, mode_a, st_ff.oc_latch, st_ff.ot_latch};
			`REG_INT_STATUS: rd[1:0] = st_ff.int_stat;
			`REG_INT_MASK: rd[1:0] = st_ff.int_mask;
			default: hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = {motor_supply_good, over_temp_trip, over_current_trip,
			current_limit_reached, chop_osc_clock};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.osc_prev = st_ff.sync2[`PIN_OSC];

		if (sys_tick) begin
			nxt_st.div = 3'h0;
			nxt_st.half = ~st_ff.half;
		end else begin
			nxt_st.div = 3'(st_ff.div + 3'h1);
		end

		// counter restarts on any gap so glitches never accumulate
		if (!oc_det)
			nxt_st.oc_cnt = 4'h0;
		else if (sys_tick && st_ff.oc_cnt != `OC_BLANK_TICKS)
			nxt_st.oc_cnt = 4'(st_ff.oc_cnt + 4'h1);
		if (!ot_det)
			nxt_st.ot_cnt = 4'h0;
		else if (half_tick && st_ff.ot_cnt != `OT_BLANK_TICKS)
			nxt_st.ot_cnt = 4'(st_ff.ot_cnt + 4'h1);

		// clear beats set: outputs stay off in standby regardless
		if (clr)
			nxt_st.oc_latch = 1'b0;
		else if (oc_ev)
			nxt_st.oc_latch = 1'b1;
		if (clr)
			nxt_st.ot_latch = 1'b0;
		else if (ot_ev)
			nxt_st.ot_latch = 1'b1;

		nxt_st.pready = setup;
		nxt_st.prdata = setup ? rd : 32'h0;
		nxt_st.pslverr = setup & ~hit;

		nxt_st.int_stat = st_ff.int_stat;
		if (access && pwrite) begin
			case (paddr)
				`REG_CTRL: nxt_st.ctrl = pwdata[2:0];
				`REG_INT_STATUS: nxt_st.int_stat = st_ff.int_stat & ~pwdata[1:0];
				`REG_INT_MASK: nxt_st.int_mask = pwdata[1:0];
				default: nxt_st.ctrl = st_ff.ctrl;
			endcase
		end
		nxt_st.int_stat = nxt_st.int_stat | events;
		nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.ctrl <= `CTRL_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two bridge channels

	chop_channel u_chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.osc_edge(osc_edge),
		.limit(st_ff.sync2[`PIN_LIM_A]),
		.dir(st_ff.ctrl[`CTRL_DIR_A]),
		.hold(hold),
		.bridge(bridge_a),
		.mode(mode_a)
	);

	chop_channel u_chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.osc_edge(osc_edge),
		.limit(st_ff.sync2[`PIN_LIM_B]),
		.dir(st_ff.ctrl[`CTRL_DIR_B]),
		.hold(hold),
		.bridge(bridge_b),
		.mode(mode_b)
	);

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign irq = st_ff.irq;

endmodule

`default_nettype wire

// File: chopper_decay_fault_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module chopper_decay_fault_control_chk
	import chop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] over_current_trip,
	input wire logic over_temp_trip,
	input wire logic motor_supply_good,
	input wire bridge_t bridge_a,
	input wire bridge_t bridge_b
);
	logic [6:0] oc_run_ff;
	logic [6:0] ot_run_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	//////////
	// saturating runs of a held trip; blanking plus sync must end well before 127
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_run_ff <= 7'h00;
			ot_run_ff <= 7'h00;
		end else begin
			oc_run_ff <= (over_current_trip == 2'h0) ? 7'h00 : oc_run_ff + 7'(oc_run_ff != 7'h7F);
			ot_run_ff <= !over_temp_trip ? 7'h00 : ot_run_ff + 7'(ot_run_ff != 7'h7F);
		end
	end
	//////////
	leg_safe_a: assert property (
		!(bridge_a[3] && bridge_a[1]) && !(bridge_a[2] && bridge_a[0])
		&& !(bridge_b[3] && bridge_b[1]) && !(bridge_b[2] && bridge_b[0]))
		else $error("shoot-through on a leg");
	legal_pattern_a: assert property (
		bridge_a inside {4'h0, 4'h9, 4'h6, 4'h3} && bridge_b inside {4'h0, 4'h9, 4'h6, 4'h3})
		else $error("illegal switch pattern");
	dead_gap_a: assert property (
		$past(bridge_a) != 4'h0 && bridge_a != $past(bridge_a) |-> bridge_a == 4'h0)
		else $error("pattern change without dead time");
	dead_len_a: assert property (
		$past(bridge_a) != 4'h0 && bridge_a == 4'h0 |=> (bridge_a == 4'h0) [*4])
		else $error("dead time too short");
	oc_off_a: assert property (
		oc_run_ff == 7'h46 |-> bridge_a == 4'h0 && bridge_b == 4'h0)
		else $error("bridges on after overcurrent");
	ot_off_a: assert property (
		ot_run_ff == 7'h7D |-> bridge_a == 4'h0 && bridge_b == 4'h0)
		else $error("bridges on after overtemperature");
	supply_off_a: assert property (
		(!motor_supply_good) [*6] |-> bridge_a == 4'h0 && bridge_b == 4'h0)
		else $error("bridges on with supply low");
	apb_answer_a: assert property (psel && !penable |=> pready && !$past(pready))
		else $error("access cycle not answered");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error flag outside access cycle");
endmodule
bind chopper_decay_fault_control chopper_decay_fault_control_chk chk_i (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .over_current_trip, .over_temp_trip,
	.motor_supply_good, .bridge_a, .bridge_b);
`default_nettype wire

// File: test_chopper_decay_fault_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "chop_regs.svh"
module test_chopper_decay_fault_control import chop_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
	logic over_temp_trip, motor_supply_good, chop_osc_clock, limit_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [1:0] current_limit_reached, over_current_trip, rev;
	bridge_t bridge_a, bridge_b;
	int bad_count, n_compared;
	chopper_decay_fault_control dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chop_osc_clock(chop_osc_clock),
		.current_limit_reached(current_limit_reached), .over_current_trip(over_current_trip),
		.over_temp_trip(over_temp_trip), .motor_supply_good(motor_supply_good),
		.bridge_a(bridge_a), .bridge_b(bridge_b), .irq(irq));
	chop_partner far (.pclk(pclk), .limit_en(limit_en), .rev(rev), .bridge_a(bridge_a),
		.bridge_b(bridge_b), .chop_osc_clock(chop_osc_clock),
		.current_limit_reached(current_limit_reached));
	always #12.5 pclk = ~pclk;
	//////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// idle cycle at the end so back-to-back calls never drive psel twice in one step
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rdata & m, e);
	endtask
	// one chopping period of channel a, from a charge start to the next
	task automatic period(input logic [3:0] c, input logic [15:0] es);
		logic [15:0] s;
		logic [3:0] last;
		int n;
		// skip the partial period after a hold release: start after a fast decay
		while (bridge_a !== es[7:4]) @(posedge pclk);
		while (bridge_a !== c) @(posedge pclk);
		s = {12'h000, c};
		last = c;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (bridge_a !== 4'h0 && bridge_a !== last) begin
				s = {s[11:0], bridge_a};
				last = bridge_a;
			end
		end while (s[15:4] == 12'h000 || last !== c);
		chk({16'h0, s}, {16'h0, es});
		chk(32'(n), 32'h80);
	endtask
	//////////
	task automatic t_regs;
		rdc(`REG_CTRL, 32'hFFFFFFFF, 32'h1);
		rdc(`REG_INT_MASK, 32'hFFFFFFFF, 32'h0);
		apb(12'h010, 1'b0, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdata, 32'h0);
	endtask
	task automatic t_chop;
		apb(`REG_CTRL, 1'b1, 32'h0);
		period(4'h9, 16'h9369);
		limit_en <= 1'b0;
		period(4'h9, 16'h0969);
		limit_en <= 1'b1;
		rev <= 2'b01;
		apb(`REG_CTRL, 1'b1, 32'h3);
		repeat (10) @(posedge pclk);
		apb(`REG_CTRL, 1'b1, 32'h2);
		period(4'h6, 16'h6396);
	endtask
	task automatic t_oc;
		apb(`REG_INT_MASK, 1'b1, 32'h3);
		over_current_trip <= 2'h1;
		repeat (30) @(posedge pclk);
		over_current_trip <= 2'h0;
		rdc(`REG_STATUS, 32'h3, 32'h0);
		over_current_trip <= 2'h2;
		repeat (80) @(posedge pclk);
		over_current_trip <= 2'h0;
		repeat (100) @(posedge pclk);
		rdc(`REG_STATUS, 32'h3, 32'h2);
		chk({24'h0, bridge_a, bridge_b}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		apb(`REG_INT_STATUS, 1'b1, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rdc(`REG_STATUS, 32'h3, 32'h2);
		apb(`REG_CTRL, 1'b1, 32'h1);
		repeat (10) @(posedge pclk);
		rdc(`REG_STATUS, 32'h3, 32'h0);
	endtask
	task automatic t_ot;
		rev <= 2'b00;
		apb(`REG_CTRL, 1'b1, 32'h0);
		over_temp_trip <= 1'b1;
		repeat (60) @(posedge pclk);
		over_temp_trip <= 1'b0;
		rdc(`REG_STATUS, 32'h3, 32'h0);
		over_temp_trip <= 1'b1;
		repeat (140) @(posedge pclk);
		over_temp_trip <= 1'b0;
		rdc(`REG_STATUS, 32'h3, 32'h1);
		rdc(`REG_INT_STATUS, 32'h1, 32'h1);
		chk({24'h0, bridge_a, bridge_b}, 32'h0);
		motor_supply_good <= 1'b0;
		repeat (8) @(posedge pclk);
		motor_supply_good <= 1'b1;
		repeat (10) @(posedge pclk);
		rdc(`REG_STATUS, 32'h3, 32'h0);
		repeat (20) @(posedge pclk);
		motor_supply_good <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({24'h0, bridge_a, bridge_b}, 32'h0);
		motor_supply_good <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
	//////////
	task automatic final_report;
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#500000;
		bad_count++;
		final_report;
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, over_temp_trip} = 6'h00;
		{paddr, pwdata, over_current_trip} = 46'h0;
		{motor_supply_good, limit_en, bad_count, n_compared} = 66'h3_0000_0000_0000_0000;
		rev = 2'b00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_chop;
		t_oc;
		t_ot;
		final_report;
	end
endmodule
`default_nettype wire
